// File: pdm_pkg.sv
// Constants and types for the pulse density sensor output stage
package pdm_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned IDLE_MS         = 90;
    localparam int unsigned IDLE_CYC        = (CLK_HZ / 1000) * IDLE_MS;
    // Modulator tick rate: one stream bit per tick
    localparam int unsigned BIT_HZ          = 65_000;
    localparam int unsigned BIT_CYC         = (CLK_HZ + BIT_HZ - 1) / BIT_HZ;
    // Reading widths
    localparam int unsigned HUM_W           = 10;
    localparam int unsigned TMP_W           = 12;
    localparam int unsigned ACC_W           = 12;
    // Reset value of the held reading
    localparam logic [11:0] VAL_RST         = 12'h000;
    // Sequencer states
    typedef enum logic [1:0] {PDM_BOOT, PDM_RUN} pdm_state_t;
endpackage

// File: pdm_buf2.sv
// Two-entry valid/ready buffer for stream bits
`timescale 1ns/10ps
module pdm_buf2
    import pdm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic in_valid_i,
    input  wire logic in_data_i,
    output logic      in_ready_o,
    output logic      out_valid_o,
    output logic      out_data_o,
    input  wire logic out_ready_i
);
    logic [1:0] mem_q;   // Storage
    logic [1:0] mem_d;
    logic       rd_q;    // Read pointer
    logic       rd_d;
    logic       wr_q;    // Write pointer
    logic       wr_d;
    logic [1:0] cnt_q;   // Fill level
    logic [1:0] cnt_d;
    logic       push;
    logic       pop;

    // Next state of pointers and storage
    always_comb
    begin
        push  = in_valid_i && (cnt_q != 2'h2);
        pop   = out_ready_i && (cnt_q != 2'h0);
        mem_d = mem_q;
        rd_d  = rd_q ^ pop;
        wr_d  = wr_q ^ push;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
        if (push)
        begin
            mem_d[wr_q] = in_data_i;
        end
    end

    // Register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mem_q <= 2'h0;
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            mem_q <= mem_d;
            rd_q  <= rd_d;
            wr_q  <= wr_d;
            cnt_q <= cnt_d;
        end
    end

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_q];
endmodule

// File: pdm_sensor_out.sv
// Output stage: selector, reading capture and pulse density modulator
`timescale 1ns/10ps
module pdm_sensor_out
    import pdm_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = IDLE_CYC
)
(
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             sel_pin_i,    // High humidity, low temperature
    input  wire logic [HUM_W-1:0] hum_i,        // Linearised humidity code
    input  wire logic [TMP_W-1:0] tmp_i,        // Linearised temperature code
    input  wire logic             meas_done_i,  // Fresh measurement pulse
    output logic                  meas_en_o,    // Measurement engine enable
    output logic                  pulse_density_modulation_o,
    output logic                  idle_o        // Idle reached
);
    // Selector synchroniser, three stages
    logic [2:0] sel_sync_q;
    logic [2:0] sel_sync_d;
    logic       sel_q;      // Accepted selector level
    logic       sel_d;
    // Boot sequencer
    pdm_state_t st_q;
    pdm_state_t st_d;
    logic [31:0] boot_q;
    logic [31:0] boot_d;
    // Held reading and modulator
    logic [ACC_W-1:0] val_q;
    logic [ACC_W-1:0] val_d;
    logic [ACC_W:0]   acc_q;
    logic [ACC_W:0]   acc_d;
    logic [15:0]      tick_q;
    logic [15:0]      tick_d;
    logic             tick;
    logic             sum_bit;
    // Buffer and output flops
    logic             b_in_ready;
    logic             b_out_valid;
    logic             b_out_data;
    logic             out_q;
    logic             out_d;
    logic             meas_q;
    logic             meas_d;

    // Scale a reading to 12-bit full scale
    function automatic logic [ACC_W-1:0] scale_hum(input logic [HUM_W-1:0] h);
        scale_hum = {h, h[HUM_W-1 -: 2]};
    endfunction

    // Synchroniser and sequencer next values
    always_comb
    begin
        sel_sync_d = {sel_sync_q[1:0], sel_pin_i};
        sel_d      = sel_q;
        if (sel_sync_q[2] == sel_sync_q[1])
        begin
            sel_d = sel_sync_q[2];
        end
        st_d   = st_q;
        boot_d = boot_q;
        meas_d = 1'b0;
        case (st_q)
            PDM_BOOT:
            begin
                // Count boot cycles up to the idle point
                if (boot_q >= IDLE_CYCLES - 1)
                begin
                    st_d = PDM_RUN;
                end
                else
                begin
                    boot_d = boot_q + 32'h1;
                end
            end
            default:
            begin
                // Measure freely, no trigger needed
                meas_d = 1'b1;
            end
        endcase
    end

    // Reading capture and modulator next values
    always_comb
    begin
        val_d = val_q;
        if (meas_done_i && st_q == PDM_RUN)
        begin
            // Humidity when high, temperature when low
            val_d = sel_q ? scale_hum(hum_i) : tmp_i;
        end
        tick   = (tick_q == 16'(BIT_CYC - 1));
        tick_d = tick ? 16'h0 : tick_q + 16'h1;
        // First order sigma delta: density follows value
        sum_bit = 1'b0;
        acc_d   = acc_q;
        if (tick && b_in_ready)
        begin
            acc_d   = {1'b0, acc_q[ACC_W-1:0]} + {1'b0, val_q};
            sum_bit = acc_d[ACC_W];
        end
        out_d = out_q;
        if (b_out_valid)
        begin
            out_d = b_out_data;
        end
    end

    pdm_buf2 u_buf (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (tick && st_q == PDM_RUN),
        .in_data_i   (sum_bit),
        .in_ready_o  (b_in_ready),
        .out_valid_o (b_out_valid),
        .out_data_o  (b_out_data),
        .out_ready_i (1'b1)
    );

    // Register all state
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sel_sync_q <= 3'h0;
            sel_q      <= 1'b0;
            st_q       <= PDM_BOOT;
            boot_q     <= 32'h0;
            val_q      <= VAL_RST;
            acc_q      <= '0;
            tick_q     <= 16'h0;
            out_q      <= 1'b0;
            meas_q     <= 1'b0;
        end
        else
        begin
            sel_sync_q <= sel_sync_d;
            sel_q      <= sel_d;
            st_q       <= st_d;
            boot_q     <= boot_d;
            val_q      <= val_d;
            acc_q      <= acc_d;
            tick_q     <= tick_d;
            out_q      <= out_d;
            meas_q     <= meas_d;
        end
    end

    assign pulse_density_modulation_o = out_q;
    assign meas_en_o                  = meas_q;
    assign idle_o                     = meas_q;

    // Stream stays low until idle
    property p_quiet_boot;
        @(posedge clk_i) disable iff (!resetn_i)
        (st_q == PDM_BOOT) |-> ##1 !pulse_density_modulation_o || st_q == PDM_RUN;
    endproperty
    a_quiet_boot: assert property (p_quiet_boot) else $error("stream before idle");

    // Measuring once running
    property p_run_meas;
        @(posedge clk_i) disable iff (!resetn_i)
        (st_q == PDM_RUN) |=> meas_en_o;
    endproperty
    a_run_meas: assert property (p_run_meas) else $error("no measurement in run");

    // Capture follows selector
    property p_sel_hum;
        @(posedge clk_i) disable iff (!resetn_i)
        (meas_done_i && st_q == PDM_RUN && sel_q) |=> val_q == scale_hum($past(hum_i));
    endproperty
    a_sel_hum: assert property (p_sel_hum) else $error("humidity not captured");

    property p_sel_tmp;
        @(posedge clk_i) disable iff (!resetn_i)
        (meas_done_i && st_q == PDM_RUN && !sel_q) |=> val_q == $past(tmp_i);
    endproperty
    a_sel_tmp: assert property (p_sel_tmp) else $error("temperature not captured");

    // Zero value never emits a high bit
    property p_zero_low;
        @(posedge clk_i) disable iff (!resetn_i)
        (tick && val_q == 12'h000 && acc_q == '0) |-> !sum_bit;
    endproperty
    a_zero_low: assert property (p_zero_low) else $error("high bit at zero");

    // Bit tick period
    property p_tick;
        @(posedge clk_i) disable iff (!resetn_i)
        tick |=> !tick [*2];
    endproperty
    a_tick: assert property (p_tick) else $error("tick too fast");

    // Bit path: a tick in run pushes one stream bit
    sequence s_bit_push;
        tick && st_q == PDM_RUN;
    endsequence

    // The pushed bit stands on the pin two edges later
    sequence s_bit_shown;
        ##2 pulse_density_modulation_o == $past(sum_bit, 2);
    endsequence

    property p_bit_path;
        @(posedge clk_i) disable iff (!resetn_i)
        s_bit_push |-> s_bit_shown;
    endproperty
    a_bit_path: assert property (p_bit_path) else $error("stream bit lost");

    // Pin moves only two edges after a tick
    property p_bit_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        $changed(pulse_density_modulation_o) |-> $past(tick, 2);
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("stream bit too short");

    // End of boot: run on the next edge, idle on the one after
    sequence s_boot_done;
        (st_q == PDM_RUN) ##1 idle_o;
    endsequence

    property p_boot_end;
        @(posedge clk_i) disable iff (!resetn_i)
        (boot_q == IDLE_CYCLES - 1) |=> s_boot_done;
    endproperty
    a_boot_end: assert property (p_boot_end) else $error("idle not reached");

    // Selector level moves only once two sync stages agree
    property p_sel_accept;
        @(posedge clk_i) disable iff (!resetn_i)
        $changed(sel_q) |-> $past(sel_sync_q[2]) == $past(sel_sync_q[1]);
    endproperty
    a_sel_accept: assert property (p_sel_accept) else $error("selector taken early");

    // Once idle, measuring never stops
    property p_idle_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        idle_o |=> idle_o && meas_en_o;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("measuring stopped");
endmodule

// File: pdm_reader_model.sv
// Reader model: measures high share and shortest run of the stream
`timescale 1ns/10ps
module pdm_reader_model
(
    input  wire logic clk_i,
    input  wire logic clr_i,     // Restart the measurement window
    input  wire logic pin_i,     // Pulse density stream
    output int        high_o,    // Cycles seen high
    output int        total_o,   // Cycles seen
    output int        run_min_o  // Shortest complete run
);
    int   run_q;   // Length of current run
    logic last_q;  // Previous level
    logic seen_q;  // A level change was seen
    // Averaging reader, like a slow low-pass filter
    always @(posedge clk_i)
    begin
        if (clr_i)
        begin
            high_o    <= 0;
            total_o   <= 0;
            run_q     <= 0;
            seen_q    <= 1'b0;
            run_min_o <= 32'h7FFFFFFF;
        end
        else
        begin
            total_o <= total_o + 1;
            high_o  <= high_o + int'(pin_i);
            // Edge: close the run, skip the partial first one
            if (pin_i !== last_q)
            begin
                if (seen_q && run_q < run_min_o)
                    run_min_o <= run_q;
                seen_q <= 1'b1;
                run_q  <= 1;
            end
            else
                run_q <= run_q + 1;
        end
        last_q <= pin_i;
    end
endmodule

// File: tb_sdm_sensor_output_select.sv
// Testbench for the pulse density sensor output stage
`timescale 1ns/10ps
module tb_sdm_sensor_output_select;
    import pdm_pkg::*;
    localparam int IDLE_SIM = 50;      // Shortened boot time
    logic        clk_i    = 1'b0;      // 100 MHz clock
    logic        resetn_i = 1'b0;      // Active low reset
    logic        sel      = 1'b0;      // Selector pin
    logic [9:0]  hum      = 10'h000;   // Humidity code
    logic [11:0] tmp      = 12'h000;   // Temperature code
    logic        done     = 1'b0;      // Fresh measurement pulse
    logic        clr      = 1'b0;      // Reader window restart
    logic        meas_en;              // Engine enable
    logic        pin;                  // Stream pin
    logic        idle;                 // Idle flag
    int          high, total, run_min; // Reader results
    int          mismatches = 0;       // Failed compares
    int          num_checks = 0;       // All compares
    int          cycles     = 0;       // Timeout counter
    int          hum_high;             // Humidity high count
    always #5 clk_i = ~clk_i;
    pdm_sensor_out #(.IDLE_CYCLES(IDLE_SIM)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .sel_pin_i(sel), .hum_i(hum), .tmp_i(tmp), .meas_done_i(done), .meas_en_o(meas_en),
        .pulse_density_modulation_o(pin), .idle_o(idle));
    pdm_reader_model i_reader (.clk_i(clk_i), .clr_i(clr), .pin_i(pin), .high_o(high),
        .total_o(total), .run_min_o(run_min));
    // Compare one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test();
        $display("mismatches %0d checks %0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Select, capture, then let the stream settle
    task automatic take(input logic s, input logic [9:0] h, input logic [11:0] t);
        sel <= s;
        hum <= h;
        tmp <= t;
        repeat (6) @(posedge clk_i);
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
        repeat (2 * BIT_CYC) @(posedge clk_i); // Stale stream discarded
    endtask
    // Measure density over some ticks against a 12-bit value
    task automatic window(input int ticks, input logic [11:0] val);
        int exp;
        int tol;
        tol = int'(2 * BIT_CYC);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (ticks * BIT_CYC) @(posedge clk_i);
        exp = (total * int'(val)) / 4096;
        check(high > exp - tol && high < exp + tol, 1'b1);
    endtask
    // Count edges since reset release until idle shows, sampled between edges
    task automatic wait_idle(input int start);
        int n;
        n = start;
        @(negedge clk_i);
        while (idle !== 1'b1 && n < IDLE_SIM + 4)
        begin
            @(negedge clk_i);
            n++;
        end
        check(n, IDLE_SIM + 1);
        @(posedge clk_i);
    endtask
    // Boot: quiet, idle in time, early capture refused
    task automatic t_boot();
        repeat (3) @(posedge clk_i);
        check({idle, meas_en, pin}, 3'h0);
        resetn_i <= 1'b1;
        sel      <= 1'b1;
        hum      <= 10'h3FF;
        tmp      <= 12'hFFF;
        repeat (6) @(posedge clk_i);
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
        wait_idle(7);
        check(meas_en, 1'b1);
        window(4, 12'h000);
        check(high, 0);
    endtask
    // Humidity: 10 bits widened by top bits, slow pulses
    task automatic t_hum();
        take(1'b1, 10'h300, 12'h000);
        window(16, 12'hC03);
        check(run_min >= BIT_CYC, 1'b1);
        hum_high = high;
    endtask
    // Temperature with a lower value
    task automatic t_tmp();
        take(1'b0, 10'h300, 12'h400);
        window(16, 12'h400);
        check(high < hum_high, 1'b1);
        check(run_min >= BIT_CYC, 1'b1);
    endtask
    // Mid-run reset: stream drops, boot repeats, reading cleared
    task automatic t_rst();
        resetn_i <= 1'b0;
        @(negedge clk_i);
        check({idle, meas_en, pin}, 3'h0);
        @(posedge clk_i);
        resetn_i <= 1'b1;
        wait_idle(0);
        window(2, 12'h000);
        check(high, 0);
    endtask
    // Hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            mismatches++;
            stop_test();
        end
    end
    // Main sequence
    initial
    begin
        t_boot();
        t_hum();
        t_tmp();
        t_rst();
        stop_test();
    end
endmodule
